/* pgs_blend.sv */
`timescale 1ns/1ns
`default_nettype none
module pgs_blend #(
	parameter int W = 16
) (
	input wire logic [W-1:0] a_in,
	input wire logic [W-1:0] b_in,
	input wire logic [10:0] weight_in,
	output logic [W-1:0] y_out
);
	logic [W+11:0] sum;
	logic [W+11:0] pa;
	logic [W+11:0] pb;
	// Weight one selects b exactly, weight zero selects a exactly
	assign pa = (W+12)'(a_in) * (W+12)'(pgs_pkg::WT_ONE - weight_in);
	assign pb = (W+12)'(b_in) * (W+12)'(weight_in);
	assign sum = pa + pb;
	assign y_out = sum[W+9:10];
endmodule : pgs_blend
`default_nettype wire

/* pgs_gain_switch.sv */
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module pgs_gain_switch #(
	parameter int TICK_CYCLES = pgs_pkg::TICK_CYCLES
) (
	input wire logic CLK_IN,
	input wire logic RST_N_IN,
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [31:0] RDATA_OUT,
	input wire logic GAIN_SEL_TERM_IN,
	input wire logic INTEG_PAUSE_TERM_IN,
	input wire logic RUN_IN,
	input wire logic CALC_TICK_IN,
	input wire logic [9:0] SETPOINT_IN,
	input wire logic [9:0] FEEDBACK_IN,
	input wire logic [9:0] RUN_FREQ_IN,
	input wire logic OUT_AT_LIMIT_IN,
	output logic [15:0] KP_OUT,
	output logic [15:0] TI_OUT,
	output logic [15:0] TD_OUT,
	output logic OUT_FORCE_OUT,
	output logic [9:0] OUT_FORCE_VALUE_OUT,
	output logic INTEG_HOLD_OUT,
	output logic CALC_ENABLE_OUT,
	output logic FEEDBACK_LOSS_FAULT_OUT,
	output logic IRQ_OUT
);
	// ----------------------------------------------------------------
	// Reset release and pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;
	logic [1:0] pin_s1_r;
	logic [1:0] pin_s2_r;
	logic term_sel;
	logic term_pause;
	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_r <= 2'h0;
			pin_s2_r <= 2'h0;
		end else begin
			pin_s1_r <= {INTEG_PAUSE_TERM_IN, GAIN_SEL_TERM_IN};
			pin_s2_r <= pin_s1_r;
		end
	end
	assign term_sel = pin_s2_r[0];
	assign term_pause = pin_s2_r[1];
	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [1:0] cond_r;
	logic sep_en_r, stop_lim_r, rws_r;
	logic [15:0] kp1_r, ti1_r, td1_r, kp2_r, ti2_r, td2_r;
	logic [9:0] err_lo_r, err_hi_r, start_val_r, loss_lvl_r;
	logic [15:0] hold_time_r;
	logic [7:0] loss_time_r;
	logic [2:0] irq_en_r;
	logic [15:0] kp2_nxt;
	logic [15:0] wd16;
	assign wd16 = WDATA_IN[15:0];
	assign kp2_nxt = (wd16 > pgs_pkg::KP2_MAX) ? pgs_pkg::KP2_MAX : wd16;
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			cond_r <= 2'h0;
			sep_en_r <= 1'b0;
			stop_lim_r <= 1'b0;
			rws_r <= 1'b0;
			kp1_r <= pgs_pkg::RST_KP;
			ti1_r <= pgs_pkg::RST_TI;
			td1_r <= pgs_pkg::RST_TD;
			kp2_r <= pgs_pkg::RST_KP;
			ti2_r <= pgs_pkg::RST_TI;
			td2_r <= pgs_pkg::RST_TD;
			err_lo_r <= pgs_pkg::RST_ERR_LO;
			err_hi_r <= pgs_pkg::RST_ERR_HI;
			start_val_r <= 10'h000;
			hold_time_r <= 16'h0000;
			loss_lvl_r <= 10'h000;
			loss_time_r <= 8'h00;
			irq_en_r <= 3'h0;
		end else if (WR_IN) begin
			case (ADDR_IN)
				pgs_pkg::OFS_CTRL: begin
					cond_r <= WDATA_IN[pgs_pkg::CTRL_COND_LSB +: 2];
					sep_en_r <= WDATA_IN[pgs_pkg::CTRL_SEP_BIT];
					stop_lim_r <= WDATA_IN[pgs_pkg::CTRL_STOPLIM_BIT];
					rws_r <= WDATA_IN[pgs_pkg::CTRL_RWS_BIT];
				end
				pgs_pkg::OFS_KP1: kp1_r <= wd16;
				pgs_pkg::OFS_TI1: ti1_r <= wd16;
				pgs_pkg::OFS_TD1: td1_r <= wd16;
				pgs_pkg::OFS_KP2: kp2_r <= kp2_nxt;
				pgs_pkg::OFS_TI2: ti2_r <= wd16;
				pgs_pkg::OFS_TD2: td2_r <= wd16;
				pgs_pkg::OFS_ERR_LO: err_lo_r <= WDATA_IN[9:0];
				pgs_pkg::OFS_ERR_HI: err_hi_r <= WDATA_IN[9:0];
				pgs_pkg::OFS_START_VAL: start_val_r <= WDATA_IN[9:0];
				pgs_pkg::OFS_HOLD_TIME: hold_time_r <= wd16;
				pgs_pkg::OFS_LOSS_LEVEL: loss_lvl_r <= WDATA_IN[9:0];
				pgs_pkg::OFS_LOSS_TIME: loss_time_r <= WDATA_IN[7:0];
				pgs_pkg::OFS_IRQ_EN: irq_en_r <= WDATA_IN[2:0];
				default: begin
				end
			endcase
		end
	end
	// ----------------------------------------------------------------
	// Gain set weighting
	// ----------------------------------------------------------------
	logic [9:0] abs_err, metric, num, den;
	logic [19:0] quot;
	logic [10:0] w_auto, weight;
	logic [15:0] kp_b, ti_b, td_b;
	logic [15:0] kp_r, ti_r, td_r;
	logic auto_mode;
	assign abs_err = (SETPOINT_IN >= FEEDBACK_IN) ? SETPOINT_IN - FEEDBACK_IN :
		FEEDBACK_IN - SETPOINT_IN;
	assign metric = (cond_r == pgs_pkg::COND_FREQ) ? RUN_FREQ_IN : abs_err;
	assign num = metric - err_lo_r;
	assign den = err_hi_r - err_lo_r;
	// Divider only used strictly between thresholds, so den is never zero there
	assign quot = (den == 10'h000) ? 20'h00000 : {num, 10'h000} / 20'(den);
	assign w_auto = (metric <= err_lo_r) ? 11'h000 :
		(metric >= err_hi_r) ? pgs_pkg::WT_ONE :
		quot[10:0];
	assign auto_mode = (cond_r == pgs_pkg::COND_ERROR) || (cond_r == pgs_pkg::COND_FREQ);
	assign weight = auto_mode ? w_auto :
		(cond_r == pgs_pkg::COND_TERMINAL && term_sel) ? pgs_pkg::WT_ONE :
		11'h000;
	pgs_blend #(.W(16)) u_kp (.a_in(kp1_r), .b_in(kp2_r), .weight_in(weight), .y_out(kp_b));
	pgs_blend #(.W(16)) u_ti (.a_in(ti1_r), .b_in(ti2_r), .weight_in(weight), .y_out(ti_b));
	pgs_blend #(.W(16)) u_td (.a_in(td1_r), .b_in(td2_r), .weight_in(weight), .y_out(td_b));
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			kp_r <= pgs_pkg::RST_KP;
			ti_r <= pgs_pkg::RST_TI;
			td_r <= pgs_pkg::RST_TD;
		end else if (CALC_TICK_IN) begin
			kp_r <= kp_b;
			ti_r <= ti_b;
			td_r <= td_b;
		end
	end
	assign KP_OUT = kp_r;
	assign TI_OUT = ti_r;
	assign TD_OUT = td_r;
	// ----------------------------------------------------------------
	// Time base, start hold and feedback loss
	// ----------------------------------------------------------------
	localparam int TW = $clog2(TICK_CYCLES + 1);
	logic [TW-1:0] div_r;
	logic tick;
	logic run_d_r;
	logic loss_cond;
	pgs_tmr_if hold_t ();
	pgs_tmr_if loss_t ();
	assign tick = (div_r == TW'(TICK_CYCLES - 1));
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			div_r <= '0;
			run_d_r <= 1'b0;
		end else begin
			div_r <= tick ? '0 : div_r + TW'(1);
			run_d_r <= RUN_IN;
		end
	end
	// Hold counter restarts from zero whenever the drive stops
	assign hold_t.tick = tick;
	assign hold_t.en = RUN_IN && run_d_r;
	assign hold_t.limit = hold_time_r;
	assign OUT_FORCE_OUT = RUN_IN && (hold_time_r != 16'h0000) &&
		!(hold_t.en && hold_t.count >= hold_time_r);
	assign OUT_FORCE_VALUE_OUT = start_val_r;
	assign loss_cond = (loss_lvl_r != 10'h000) && (FEEDBACK_IN < loss_lvl_r);
	assign loss_t.tick = tick;
	assign loss_t.en = loss_cond && CALC_ENABLE_OUT;
	assign loss_t.limit = 16'(loss_time_r) * 16'(pgs_pkg::LOSS_TICKS_PER_UNIT);
	assign FEEDBACK_LOSS_FAULT_OUT = loss_t.expired;
	pgs_timer u_hold (.clk(CLK_IN), .rst_n(rst_n), .t(hold_t));
	pgs_timer u_loss (.clk(CLK_IN), .rst_n(rst_n), .t(loss_t));
	// ----------------------------------------------------------------
	// Integral control and run gating
	// ----------------------------------------------------------------
	assign INTEG_HOLD_OUT = (sep_en_r && term_pause) ||
		(stop_lim_r && OUT_AT_LIMIT_IN) || OUT_FORCE_OUT;
	assign CALC_ENABLE_OUT = RUN_IN || rws_r;
	// ----------------------------------------------------------------
	// Interrupts: loss fault, hold finished, active Kp changed at a calc tick
	// ----------------------------------------------------------------
	logic fault_d_r, force_d_r;
	logic [2:0] irq_st_r, irq_ev, irq_clr;
	logic [2:0] irq_st_nxt;
	assign irq_ev[0] = FEEDBACK_LOSS_FAULT_OUT && !fault_d_r;
	assign irq_ev[1] = force_d_r && !OUT_FORCE_OUT;
	assign irq_ev[2] = CALC_TICK_IN && (kp_b != kp_r);
	assign irq_clr = (WR_IN && ADDR_IN == pgs_pkg::OFS_IRQ_CLR) ? WDATA_IN[2:0] : 3'h0;
	// Set wins over a clear landing in the same cycle
	assign irq_st_nxt = (irq_st_r & ~irq_clr) | irq_ev;
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			irq_st_r <= 3'h0;
			fault_d_r <= 1'b0;
			force_d_r <= 1'b0;
		end else begin
			irq_st_r <= irq_st_nxt;
			fault_d_r <= FEEDBACK_LOSS_FAULT_OUT;
			force_d_r <= OUT_FORCE_OUT;
		end
	end
	assign IRQ_OUT = |(irq_st_r & irq_en_r);
	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [31:0] rd_mux;
	logic [31:0] rdata_r;
	always_comb begin
		case (ADDR_IN)
			pgs_pkg::OFS_CTRL: rd_mux = {23'h0, rws_r, 2'h0, stop_lim_r, sep_en_r, 2'h0, cond_r};
			pgs_pkg::OFS_KP1: rd_mux = {16'h0, kp1_r};
			pgs_pkg::OFS_TI1: rd_mux = {16'h0, ti1_r};
			pgs_pkg::OFS_TD1: rd_mux = {16'h0, td1_r};
			pgs_pkg::OFS_KP2: rd_mux = {16'h0, kp2_r};
			pgs_pkg::OFS_TI2: rd_mux = {16'h0, ti2_r};
			pgs_pkg::OFS_TD2: rd_mux = {16'h0, td2_r};
			pgs_pkg::OFS_ERR_LO: rd_mux = {22'h0, err_lo_r};
			pgs_pkg::OFS_ERR_HI: rd_mux = {22'h0, err_hi_r};
			pgs_pkg::OFS_START_VAL: rd_mux = {22'h0, start_val_r};
			pgs_pkg::OFS_HOLD_TIME: rd_mux = {16'h0, hold_time_r};
			pgs_pkg::OFS_LOSS_LEVEL: rd_mux = {22'h0, loss_lvl_r};
			pgs_pkg::OFS_LOSS_TIME: rd_mux = {24'h0, loss_time_r};
			pgs_pkg::OFS_STATUS: rd_mux = {17'h0, weight, CALC_ENABLE_OUT,
				INTEG_HOLD_OUT, FEEDBACK_LOSS_FAULT_OUT, OUT_FORCE_OUT};
			pgs_pkg::OFS_IRQ_STAT: rd_mux = {29'h0, irq_st_r};
			pgs_pkg::OFS_IRQ_EN: rd_mux = {29'h0, irq_en_r};
			pgs_pkg::OFS_ACT_KP: rd_mux = {16'h0, kp_r};
			pgs_pkg::OFS_ACT_TI: rd_mux = {16'h0, ti_r};
			pgs_pkg::OFS_ACT_TD: rd_mux = {16'h0, td_r};
			default: rd_mux = 32'h00000000;
		endcase
	end
	always_ff @(posedge CLK_IN or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 32'h00000000;
		end else if (RD_IN) begin
			rdata_r <= rd_mux;
		end
	end
	assign RDATA_OUT = rdata_r;
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_never_switch: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(CALC_TICK_IN && cond_r == 2'h0) |=> (kp_r == $past(kp1_r) && td_r == $past(td1_r)))
		else $error("gain set two used while switching disabled");
	a_kp2_cap: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		kp2_r <= pgs_pkg::KP2_MAX) else $error("second gain above 100.0");
	a_term_select: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(CALC_TICK_IN && cond_r == 2'h1) |=>
		(ti_r == ($past(term_sel) ? $past(ti2_r) : $past(ti1_r))))
		else $error("terminal did not select gain set");
	a_err_low: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(CALC_TICK_IN && cond_r == 2'h2 && abs_err < err_lo_r) |=> kp_r == $past(kp1_r))
		else $error("small error did not give set one");
	a_err_high: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(CALC_TICK_IN && cond_r == 2'h2 && abs_err > err_hi_r) |=> kp_r == $past(kp2_r))
		else $error("large error did not give set two");
	a_blend_bound: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(CALC_TICK_IN && cond_r == 2'h2 && abs_err > err_lo_r && abs_err < err_hi_r
		&& kp1_r <= kp2_r) |=> (kp_r >= $past(kp1_r) && kp_r <= $past(kp2_r)))
		else $error("interpolated gain outside its two sets");
	a_hold_force: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		($rose(RUN_IN) && hold_time_r != 16'h0000) |-> OUT_FORCE_OUT [*3])
		else $error("output not forced after start");
	a_integ_pause: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(sep_en_r && $past(INTEG_PAUSE_TERM_IN, 2)) |-> INTEG_HOLD_OUT)
		else $error("pause terminal did not freeze integral");
	a_sep_off: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(!sep_en_r && !stop_lim_r && !OUT_FORCE_OUT) |-> !INTEG_HOLD_OUT)
		else $error("integral frozen with separation disabled");
	a_limit_stop: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(stop_lim_r && OUT_AT_LIMIT_IN) |-> INTEG_HOLD_OUT)
		else $error("integral kept running at output limit");
	a_loss_off: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(loss_lvl_r == 10'h000) [*2] |-> !FEEDBACK_LOSS_FAULT_OUT)
		else $error("loss fault with detection disabled");
	a_loss_early: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		$rose(FEEDBACK_LOSS_FAULT_OUT) |-> loss_t.count > loss_t.limit && $past(loss_t.en))
		else $error("loss fault before loss time elapsed");
	a_stop_idle: assert property (@(posedge CLK_IN) disable iff (!rst_n)
		(!RUN_IN && !rws_r) |-> !CALC_ENABLE_OUT)
		else $error("regulator computing while stopped");
endmodule : pgs_gain_switch
`default_nettype wire

/* pgs_pkg.sv */
package pgs_pkg;
	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_MS = 10;
	localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
	localparam int LOSS_TICKS_PER_UNIT = 100 / TICK_MS;
	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_KP1 = 8'h04;
	localparam logic [7:0] OFS_TI1 = 8'h08;
	localparam logic [7:0] OFS_TD1 = 8'h0C;
	localparam logic [7:0] OFS_KP2 = 8'h10;
	localparam logic [7:0] OFS_TI2 = 8'h14;
	localparam logic [7:0] OFS_TD2 = 8'h18;
	localparam logic [7:0] OFS_ERR_LO = 8'h1C;
	localparam logic [7:0] OFS_ERR_HI = 8'h20;
	localparam logic [7:0] OFS_START_VAL = 8'h24;
	localparam logic [7:0] OFS_HOLD_TIME = 8'h28;
	localparam logic [7:0] OFS_LOSS_LEVEL = 8'h2C;
	localparam logic [7:0] OFS_LOSS_TIME = 8'h30;
	localparam logic [7:0] OFS_STATUS = 8'h34;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h38;
	localparam logic [7:0] OFS_IRQ_CLR = 8'h3C;
	localparam logic [7:0] OFS_IRQ_EN = 8'h40;
	localparam logic [7:0] OFS_ACT_KP = 8'h44;
	localparam logic [7:0] OFS_ACT_TI = 8'h48;
	localparam logic [7:0] OFS_ACT_TD = 8'h4C;
	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_COND_LSB = 0;
	localparam int CTRL_SEP_BIT = 4;
	localparam int CTRL_STOPLIM_BIT = 5;
	localparam int CTRL_RWS_BIT = 8;
	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_KP = 16'h00C8;
	localparam logic [15:0] RST_TI = 16'h00C8;
	localparam logic [15:0] RST_TD = 16'h0000;
	localparam logic [15:0] KP2_MAX = 16'h03E8;
	localparam logic [9:0] RST_ERR_LO = 10'h0C8;
	localparam logic [9:0] RST_ERR_HI = 10'h320;
	localparam logic [10:0] WT_ONE = 11'h400;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		COND_NEVER,
		COND_TERMINAL,
		COND_ERROR,
		COND_FREQ
	} pgs_cond_t;
endpackage : pgs_pkg

/* pgs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic CLK_IN = 1'b0;
	logic RST_N_IN = 1'b0;
	logic [7:0] ADDR_IN = 8'h00;
	logic [31:0] WDATA_IN = 32'h0;
	logic WR_IN = 1'b0, RD_IN = 1'b0;
	logic GAIN_SEL_TERM_IN = 1'b0, INTEG_PAUSE_TERM_IN = 1'b0, RUN_IN = 1'b0;
	logic CALC_TICK_IN = 1'b0, OUT_AT_LIMIT_IN = 1'b0;
	logic [9:0] SETPOINT_IN = 10'h0, FEEDBACK_IN = 10'h0, RUN_FREQ_IN = 10'h0;
	logic [31:0] RDATA_OUT;
	logic [15:0] KP_OUT, TI_OUT, TD_OUT;
	logic [9:0] OUT_FORCE_VALUE_OUT;
	logic OUT_FORCE_OUT, INTEG_HOLD_OUT, CALC_ENABLE_OUT, FEEDBACK_LOSS_FAULT_OUT, IRQ_OUT;
	int failures = 0;
	int total_checks = 0;
	logic [31:0] d;
	// --------------------------------------------------------------
	// Clock, dut
	// --------------------------------------------------------------
	always #20 CLK_IN = ~CLK_IN;
	// Short tick keeps hold and loss timers to a few dozen cycles
	pgs_gain_switch #(.TICK_CYCLES(4)) i_dut (.CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN),
		.ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN), .WR_IN(WR_IN), .RD_IN(RD_IN),
		.RDATA_OUT(RDATA_OUT), .GAIN_SEL_TERM_IN(GAIN_SEL_TERM_IN),
		.INTEG_PAUSE_TERM_IN(INTEG_PAUSE_TERM_IN), .RUN_IN(RUN_IN),
		.CALC_TICK_IN(CALC_TICK_IN), .SETPOINT_IN(SETPOINT_IN), .FEEDBACK_IN(FEEDBACK_IN),
		.RUN_FREQ_IN(RUN_FREQ_IN), .OUT_AT_LIMIT_IN(OUT_AT_LIMIT_IN), .KP_OUT(KP_OUT),
		.TI_OUT(TI_OUT), .TD_OUT(TD_OUT), .OUT_FORCE_OUT(OUT_FORCE_OUT),
		.OUT_FORCE_VALUE_OUT(OUT_FORCE_VALUE_OUT), .INTEG_HOLD_OUT(INTEG_HOLD_OUT),
		.CALC_ENABLE_OUT(CALC_ENABLE_OUT), .FEEDBACK_LOSS_FAULT_OUT(FEEDBACK_LOSS_FAULT_OUT),
		.IRQ_OUT(IRQ_OUT));
	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK_IN);
		WR_IN <= 1'b1;
		ADDR_IN <= a;
		WDATA_IN <= v;
		@(posedge CLK_IN);
		WR_IN <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge CLK_IN);
		RD_IN <= 1'b1;
		ADDR_IN <= a;
		@(posedge CLK_IN);
		RD_IN <= 1'b0;
		@(posedge CLK_IN);
		v = RDATA_OUT;
	endtask : rd
	task automatic tick();
		repeat (4) @(posedge CLK_IN);
		CALC_TICK_IN <= 1'b1;
		@(posedge CLK_IN);
		CALC_TICK_IN <= 1'b0;
		#1;
	endtask : tick
	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] ofs [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h00, 8'hFC};
		logic [31:0] exp [8] = '{32'hC8, 32'hC8, 32'h0, 32'hC8, 32'hC8, 32'h0, 32'h0, 32'h0};
		chk({KP_OUT, TI_OUT}, 32'h00C800C8);
		chk(TD_OUT, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			rd(ofs[i], d);
			chk(d, exp[i]);
		end
		wr(8'h10, 32'h7D0);
		rd(8'h10, d);
		chk(d, 32'h3E8);
		$display("test reset values done");
	endtask : t_reset
	task automatic t_gains();
		logic [1:0] cnd [8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
		logic trm [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		logic [9:0] sp [8] = '{10'h1F4, 10'h1F4, 10'h1F4, 10'h1F4, 10'h3E8, 10'h064,
			10'h1F4, 10'h1F4};
		logic [9:0] fq [8] = '{10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000,
			10'h384, 10'h064};
		logic [15:0] exp [8] = '{16'h0064, 16'h01F4, 16'h0064, 16'h0064, 16'h01F4,
			16'h012C, 16'h01F4, 16'h0064};
		wr(8'h04, 32'h64);
		wr(8'h10, 32'h1F4);
		for (int i = 0; i < 8; i++) begin
			wr(8'h00, {30'h0, cnd[i]});
			GAIN_SEL_TERM_IN <= trm[i];
			SETPOINT_IN <= sp[i];
			FEEDBACK_IN <= (i == 5) ? 10'h258 : ((i == 4) ? 10'h064 : 10'h190);
			RUN_FREQ_IN <= fq[i];
			tick();
			chk(KP_OUT, exp[i]);
		end
		rd(8'h44, d);
		chk(d, 32'h64);
		// Frequency half way between thresholds gives weight one half
		RUN_FREQ_IN <= 10'h1F4;
		rd(8'h34, d);
		chk(d, 32'h2008);
		$display("test gain switching done");
	endtask : t_gains
	task automatic t_integ();
		logic [31:0] ctl [4] = '{32'h10, 32'h00, 32'h20, 32'h00};
		logic pau [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
		logic lim [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
		logic exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			wr(8'h00, ctl[i]);
			INTEG_PAUSE_TERM_IN <= pau[i];
			OUT_AT_LIMIT_IN <= lim[i];
			repeat (5) @(posedge CLK_IN);
			#1 chk(INTEG_HOLD_OUT, exp[i]);
		end
		@(posedge CLK_IN);
		OUT_AT_LIMIT_IN <= 1'b0;
		$display("test integral freeze done");
	endtask : t_integ
	task automatic t_loss();
		FEEDBACK_IN <= 10'h000;
		repeat (70) @(posedge CLK_IN);
		#1 chk(FEEDBACK_LOSS_FAULT_OUT, 1'b0);
		// Time before level, so detection never runs against a zero limit
		wr(8'h30, 32'h1);
		wr(8'h2C, 32'h1F4);
		FEEDBACK_IN <= 10'h064;
		repeat (30) @(posedge CLK_IN);
		#1 chk(FEEDBACK_LOSS_FAULT_OUT, 1'b0);
		rd(8'h38, d);
		chk(d & 32'h1, 32'h0);
		repeat (40) @(posedge CLK_IN);
		#1 chk(FEEDBACK_LOSS_FAULT_OUT, 1'b1);
		rd(8'h38, d);
		chk(d & 32'h1, 32'h1);
		FEEDBACK_IN <= 10'h384;
		repeat (4) @(posedge CLK_IN);
		#1 chk(FEEDBACK_LOSS_FAULT_OUT, 1'b0);
		$display("test feedback loss done");
	endtask : t_loss
	task automatic t_hold();
		@(posedge CLK_IN);
		RUN_IN <= 1'b0;
		wr(8'h24, 32'h155);
		wr(8'h28, 32'h3);
		wr(8'h3C, 32'h7);
		wr(8'h40, 32'h2);
		chk(IRQ_OUT, 1'b0);
		RUN_IN <= 1'b1;
		repeat (5) @(posedge CLK_IN);
		#1 chk({OUT_FORCE_OUT, OUT_FORCE_VALUE_OUT}, 11'h555);
		repeat (20) @(posedge CLK_IN);
		#1 chk(OUT_FORCE_OUT, 1'b0);
		chk(IRQ_OUT, 1'b1);
		wr(8'h3C, 32'h2);
		@(posedge CLK_IN);
		#1 chk(IRQ_OUT, 1'b0);
		wr(8'h40, 32'h0);
		$display("test start hold done");
	endtask : t_hold
	task automatic t_stop();
		RUN_IN <= 1'b0;
		wr(8'h00, 32'h0);
		#1 chk(CALC_ENABLE_OUT, 1'b0);
		wr(8'h00, 32'h100);
		@(posedge CLK_IN);
		#1 chk(CALC_ENABLE_OUT, 1'b1);
		$display("test run when stopped done");
	endtask : t_stop
	// --------------------------------------------------------------
	// Sequence and verdict
	// --------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial begin
		// Watchdog well beyond the few hundred cycles the tests need
		#400000;
		failures++;
		give_verdict();
	end
	initial begin
		repeat (6) @(posedge CLK_IN);
		RST_N_IN <= 1'b1;
		repeat (3) @(posedge CLK_IN);
		t_reset();
		RUN_IN <= 1'b1;
		t_gains();
		t_integ();
		t_loss();
		t_hold();
		t_stop();
		give_verdict();
	end
endmodule : tb
`default_nettype wire

/* pgs_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module pgs_timer (
	input wire logic clk,
	input wire logic rst_n,
	pgs_tmr_if.tmr t
);
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	// Saturates so a long dwell never wraps back below the limit
	assign cnt_nxt = !t.en ? 16'h0000 :
		(t.tick && cnt_r != 16'hFFFF) ? cnt_r + 16'h0001 : cnt_r;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
	assign t.count = cnt_r;
	assign t.expired = t.en && (cnt_r > t.limit);
endmodule : pgs_timer
`default_nettype wire

/* pgs_tmr_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface pgs_tmr_if;
	logic tick;
	logic en;
	logic [15:0] limit;
	logic [15:0] count;
	logic expired;
	modport ctl (output tick, output en, output limit, input count, input expired);
	modport tmr (input tick, input en, input limit, output count, output expired);
endinterface : pgs_tmr_if
`default_nettype wire
